// [rtl/watchdog_defs.vh]
// shared constants of the watchdog block: map, fields, reset values, timing
`ifndef WATCHDOG_DEFS_VH
`define WATCHDOG_DEFS_VH

// byte address of the control/counter register
`define WDR_OFFSET        8'hD8
// reset image of the register
`define WDR_RESET         8'hFE
// field positions inside the register
`define WDR_ACT_BIT       0
`define WDR_SRST_BIT      1
`define WDR_PER_LO        2
`define WDR_PER_HI        7
// physical counter width and trip bit
`define CNT_W             7
`define CNT_TRIP_BIT      6
// counter reset image, all ones
`define CNT_RESET         7'h7F
// processor cycles per counter step
`define PRESCALE_CYCLES   3072
// internal clock cycles from reset release to internal release
`define RST_DELAY_CYCLES  2048
// axi response codes
`define RESP_OKAY         2'h0
`define RESP_SLVERR       2'h2
// low power state codes
`define PS_RUN            2'h0
`define PS_WAIT           2'h1
`define PS_STOP           2'h2

`endif

// [rtl/tick_divider.v]
// prescaler giving a one-cycle step pulse every DIV enabled cycles
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module tick_divider #(
    parameter DIV = `PRESCALE_CYCLES,
    parameter W   = 12
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         clear,
    input  wire         enable,
    output reg          tick_r
);
    reg [W-1:0] cnt_r;                 // cycles counted in this interval

    // count enabled cycles, pulse at the end of each interval
    always @(posedge aclk) begin
        if (!aresetn || clear) begin
            cnt_r  <= {W{1'b0}};
            tick_r <= 1'b0;
        end else if (enable) begin
            if (cnt_r == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
                cnt_r  <= {W{1'b0}};
                tick_r <= 1'b1;
            end else begin
                cnt_r  <= cnt_r + {{(W-1){1'b0}}, 1'b1};
                tick_r <= 1'b0;
            end
        end else begin
            tick_r <= 1'b0;            // frozen: no steps
        end
    end
endmodule

// [rtl/reset_stretcher.v]
// internal reset generator: holds reset DELAY cycles after source release
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module reset_stretcher #(
    parameter DELAY = `RST_DELAY_CYCLES,
    parameter W     = 12
) (
    input  wire         aclk,
    input  wire         aresetn,
    input  wire         src_active,
    output reg          rst_r
);
    reg [W-1:0] cnt_r;                 // cycles since source released

    // restart the delay on any source, release at the end of it
    always @(posedge aclk) begin
        if (!aresetn || src_active) begin
            cnt_r <= {W{1'b0}};
            rst_r <= 1'b1;
        end else if (rst_r) begin
            if (cnt_r == DELAY[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
                rst_r <= 1'b0;
            end else begin
                cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            end
        end
    end
endmodule

// [rtl/digital_watchdog_reset.v]
// watchdog downcounter with internal reset, stop control and axi4-lite port
`timescale 1ns/1ps
`include "watchdog_defs.vh"

module digital_watchdog_reset #(
    parameter ADDR_W = 8
) (
    input  wire              aclk,
    input  wire              aresetn,
    // axi4-lite slave
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output reg               s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output reg               s_axi_wready,
    output reg  [1:0]        s_axi_bresp,
    output reg               s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output reg               s_axi_arready,
    output reg  [31:0]       s_axi_rdata,
    output reg  [1:0]        s_axi_rresp,
    output reg               s_axi_rvalid,
    input  wire              s_axi_rready,
    // device pins
    input  wire              ext_reset_n_pin,
    input  wire              nmi_pin,
    // option straps, static configuration
    input  wire              hw_activation_opt,
    input  wire              ext_stop_opt,
    // processor side events, one-cycle pulses
    input  wire              stop_exec,
    input  wire              wake_irq,
    // status outputs
    output reg               mcu_reset_r,
    output reg               osc_halted_r,
    output reg               cpu_wait_r,
    output reg               wdg_active_r
);

    // register image to physical counter: bit 7 to lsb
    function [`CNT_W-1:0] reg_to_cnt;
        input [7:0] v;
        integer i;
        begin
            for (i = 0; i < 6; i = i + 1)
                reg_to_cnt[i] = v[`WDR_PER_HI - i];
            reg_to_cnt[`CNT_TRIP_BIT] = v[`WDR_SRST_BIT];
        end
    endfunction

    // physical counter to register image
    function [7:0] cnt_to_reg;
        input [`CNT_W-1:0] c;
        input              act;
        integer i;
        begin
            cnt_to_reg = 8'h00;
            for (i = 0; i < 6; i = i + 1)
                cnt_to_reg[`WDR_PER_HI - i] = c[i];
            cnt_to_reg[`WDR_SRST_BIT] = c[`CNT_TRIP_BIT];
            cnt_to_reg[`WDR_ACT_BIT]  = act;
        end
    endfunction

    // pin synchronisers
    reg         rstpin_s1_r;           // first stage, reset pin
    reg         rstpin_s2_r;           // second stage, reset pin
    reg         nmi_s1_r;              // first stage, nmi pin
    reg         nmi_s2_r;              // second stage, nmi pin

    // watchdog state
    reg  [`CNT_W-1:0] cnt_r;           // physical downcounter
    reg  [`CNT_W-1:0] cnt_nxt;
    reg               act_r;           // activation bit
    reg               act_nxt;
    reg               hw_opt_r;        // latched hardware option
    reg               xs_opt_r;        // latched external stop option
    reg               trip_r;          // watchdog reset request
    reg               trip_nxt;
    reg  [1:0]        pstate_r;        // run, wait or stop
    reg  [1:0]        pstate_nxt;

    // bus holding state
    reg               aw_hold_r;       // write address captured
    reg  [ADDR_W-1:0] waddr_r;         // captured write address
    reg               w_hold_r;        // write data captured
    reg  [7:0]        wbyte_r;         // captured low data byte
    reg               wlane_r;         // low byte lane enabled

    wire              int_rst;         // internal reset from stretcher
    wire              step;            // prescaler step pulse
    wire              do_write;        // write committed this cycle
    wire              hit_w;           // write hits the register
    wire              reg_wr;          // write changes the register
    wire              frozen;          // counter held in stop mode
    wire              act_eff;         // activation as seen by logic

    assign do_write = aw_hold_r && w_hold_r && !s_axi_bvalid;
    assign hit_w    = (waddr_r == `WDR_OFFSET);
    assign reg_wr   = do_write && hit_w && wlane_r;
    assign frozen   = (pstate_r == `PS_STOP);
    assign act_eff  = act_r || hw_opt_r;

    // two flip-flops on each pin before use
    always @(posedge aclk) begin
        if (!aresetn) begin
            rstpin_s1_r <= 1'b0;
            rstpin_s2_r <= 1'b0;
            nmi_s1_r    <= 1'b0;
            nmi_s2_r    <= 1'b0;
        end else begin
            rstpin_s1_r <= ext_reset_n_pin;
            rstpin_s2_r <= rstpin_s1_r;
            nmi_s1_r    <= nmi_pin;
            nmi_s2_r    <= nmi_s1_r;
        end
    end

    // pin and watchdog share one path
    reset_stretcher #(
        .DELAY (`RST_DELAY_CYCLES),
        .W     (12)
    ) u_rst (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .src_active (!rstpin_s2_r || trip_r),
        .rst_r      (int_rst)
    );

    tick_divider #(
        .DIV (`PRESCALE_CYCLES),
        .W   (12)
    ) u_div (
        .aclk    (aclk),
        .aresetn (aresetn),
        .clear   (int_rst || (act_nxt && !act_eff)),
        .enable  (!frozen),
        .tick_r  (step)
    );

    // latch option straps while in reset
    always @(posedge aclk) begin
        if (!aresetn) begin
            hw_opt_r <= 1'b0;
            xs_opt_r <= 1'b0;
        end else if (int_rst) begin
            hw_opt_r <= hw_activation_opt;
            xs_opt_r <= ext_stop_opt;
        end
    end

    // next counter, activation and trip
    always @* begin
        cnt_nxt  = cnt_r;
        act_nxt  = act_eff;
        trip_nxt = 1'b0;
        if (int_rst) begin
            cnt_nxt = reg_to_cnt(`WDR_RESET);
            act_nxt = 1'b0;
        end else begin
            if (reg_wr) begin
                cnt_nxt = reg_to_cnt(wbyte_r);
                act_nxt = act_eff || wbyte_r[`WDR_ACT_BIT];
            end else if (step) begin
                cnt_nxt = cnt_r - {{(`CNT_W-1){1'b0}}, 1'b1};
            end
            if (act_nxt && cnt_r[`CNT_TRIP_BIT]
                && !cnt_nxt[`CNT_TRIP_BIT])
                trip_nxt = 1'b1;
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r        <= `CNT_RESET;
            act_r        <= 1'b0;
            trip_r       <= 1'b0;
            mcu_reset_r  <= 1'b1;
            wdg_active_r <= 1'b0;
        end else begin
            cnt_r        <= cnt_nxt;
            act_r        <= act_nxt;
            trip_r       <= trip_nxt;
            mcu_reset_r  <= int_rst;
            wdg_active_r <= int_rst ? 1'b0 : (act_nxt || hw_opt_r);
        end
    end

    // low power mode selection on stop and wake
    always @* begin
        pstate_nxt = pstate_r;
        case (pstate_r)
            `PS_RUN: begin
                if (stop_exec) begin
                    if (!act_eff)
                        pstate_nxt = `PS_STOP;
                    else if (!xs_opt_r)
                        pstate_nxt = `PS_WAIT;
                    else if (!nmi_s2_r)
                        pstate_nxt = `PS_WAIT;
                    else
                        pstate_nxt = `PS_STOP;
                end
            end
            `PS_WAIT: begin
                if (wake_irq)
                    pstate_nxt = `PS_RUN;
            end
            `PS_STOP: begin
                if (wake_irq)
                    pstate_nxt = `PS_RUN;
            end
            default: begin
                pstate_nxt = `PS_RUN;
            end
        endcase
    end

    // power state register and its outputs
    always @(posedge aclk) begin
        if (!aresetn || int_rst) begin
            pstate_r     <= `PS_RUN;
            osc_halted_r <= 1'b0;
            cpu_wait_r   <= 1'b0;
        end else begin
            pstate_r     <= pstate_nxt;
            osc_halted_r <= (pstate_nxt == `PS_STOP);
            cpu_wait_r   <= (pstate_nxt == `PS_WAIT);
        end
    end

    // write address and data capture, response
    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r     <= 1'b0;
            waddr_r       <= {ADDR_W{1'b0}};
            w_hold_r      <= 1'b0;
            wbyte_r       <= 8'h00;
            wlane_r       <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
        end else begin
            // address channel
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r     <= 1'b1;
                waddr_r       <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            // data channel
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r     <= 1'b1;
                wbyte_r      <= s_axi_wdata[7:0];
                wlane_r      <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            // both held: commit and answer
            if (do_write) begin
                aw_hold_r     <= 1'b0;
                w_hold_r      <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= hit_w ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // read channel: one read at a time
    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h00000000;
            s_axi_rresp   <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            if (s_axi_araddr == `WDR_OFFSET) begin
                s_axi_rdata <= {24'h000000, cnt_to_reg(cnt_r, act_eff)};
                s_axi_rresp <= `RESP_OKAY;
            end else begin
                // unmapped address
                s_axi_rdata <= 32'h00000000;
                s_axi_rresp <= `RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

endmodule

// [verif/digital_watchdog_reset_monitor.sv]
// concurrent checks on the watchdog block ports
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module digital_watchdog_reset_monitor (
    input wire        aclk,
    input wire        aresetn,
    input wire        s_axi_awvalid,
    input wire        s_axi_awready,
    input wire        s_axi_wvalid,
    input wire        s_axi_wready,
    input wire        s_axi_bvalid,
    input wire        s_axi_arvalid,
    input wire        s_axi_arready,
    input wire        s_axi_rvalid,
    input wire [31:0] s_axi_rdata,
    input wire [1:0]  s_axi_rresp,
    input wire        stop_exec,
    input wire        wake_irq,
    input wire        mcu_reset_r,
    input wire        osc_halted_r,
    input wire        cpu_wait_r,
    input wire        wdg_active_r
);
    logic [11:0] hi_cnt_r; // cycles with internal reset held high
    // count the length of each internal reset pulse
    always_ff @(posedge aclk) begin
        if (!aresetn || !mcu_reset_r) begin
            hi_cnt_r <= 12'h000;
        end else if (hi_cnt_r != 12'hFFF) begin
            hi_cnt_r <= hi_cnt_r + 12'h001;
        end
    end
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // bus and processor events
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence s_stop_run;
        stop_exec && !mcu_reset_r && !osc_halted_r && !cpu_wait_r;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_taken |=> !s_axi_awready
        && !s_axi_wready ##1 s_axi_bvalid) else $error("write not answered");
    AST_RD_ANSWER: assert property (s_rd_taken |=> s_axi_rvalid
        && !s_axi_arready) else $error("read not answered");
    AST_RST_HOLD: assert property ($fell(mcu_reset_r) |->
        hi_cnt_r >= 12'h7FF) else $error("internal reset too short");
    AST_ACT_STICKS: assert property (wdg_active_r && !mcu_reset_r
        |=> (wdg_active_r or ##[0:2] mcu_reset_r))
        else $error("watchdog deactivated without reset");
    AST_RD_RESET_IMG: assert property ($rose(s_axi_rvalid)
        && $past(mcu_reset_r) && s_axi_rresp == `RESP_OKAY
        |-> s_axi_rdata[7:1] == 7'h7F)
        else $error("register not at reset image");
    AST_STOP_HALTS: assert property (s_stop_run ##0 !wdg_active_r
        |=> osc_halted_r) else $error("inactive stop did not halt");
    AST_STOP_MODE: assert property (s_stop_run ##0 wdg_active_r
        |=> osc_halted_r ^ cpu_wait_r) else $error("active stop mode wrong");
    AST_WAKE_RUN: assert property (wake_irq && !mcu_reset_r
        |=> !osc_halted_r && !cpu_wait_r) else $error("wake did not run");
    AST_HALT_CAUSE: assert property ($rose(osc_halted_r) |->
        $past(stop_exec) && !$past(cpu_wait_r)) else $error("halt uncaused");
endmodule
bind digital_watchdog_reset digital_watchdog_reset_monitor mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .stop_exec(stop_exec),
    .wake_irq(wake_irq), .mcu_reset_r(mcu_reset_r),
    .osc_halted_r(osc_halted_r), .cpu_wait_r(cpu_wait_r),
    .wdg_active_r(wdg_active_r));

// [verif/digital_watchdog_reset_tb.sv]
// self-checking bench for the watchdog block
`timescale 1ns/1ps
`include "watchdog_defs.vh"
module digital_watchdog_reset_tb;
    logic        aclk = 0, aresetn = 0;
    logic [7:0]  awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, r;
    logic [3:0]  wstrb = 0;
    logic [1:0]  bresp, rresp;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0;
    logic        rready = 0, pin_n = 1, nmi = 0, hw = 0, ext = 0;
    logic        stop = 0, wake = 0, awready, wready, bvalid, arready;
    logic        rvalid, mcu_reset_r, osc_halted_r, cpu_wait_r, act;
    logic [33:0] rq[$], exp_r; // expected read answers
    logic [1:0]  bq[$], exp_b; // expected write answers
    int          err_count = 0, num_checks = 0, cyc = 0;
    integer      seed; // random seed
    always #20 aclk = ~aclk;
    digital_watchdog_reset uut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .ext_reset_n_pin(pin_n), .nmi_pin(nmi),
        .hw_activation_opt(hw), .ext_stop_opt(ext), .stop_exec(stop),
        .wake_irq(wake), .mcu_reset_r(mcu_reset_r),
        .osc_halted_r(osc_halted_r), .cpu_wait_r(cpu_wait_r),
        .wdg_active_r(act));
    // verdict and end of run
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // watcher: compare each bus answer with the oldest note
    always @(posedge aclk) begin
        cyc++;
        if (rvalid === 1'b1 && rready === 1'b1) begin
            exp_r = rq.pop_front();
            num_checks++;
            if ({rresp, rdata} !== exp_r) begin
                err_count++;
                $display("unexpected read: exp %h seen %h", exp_r,
                         {rresp, rdata});
            end
        end
        if (bvalid === 1'b1 && bready === 1'b1) begin
            exp_b = bq.pop_front();
            num_checks++;
            if (bresp !== exp_b) begin
                err_count++;
                $display("unexpected bresp: exp %h seen %h", exp_b, bresp);
            end
        end
        if (cyc == 60000) begin
            err_count++;
            $display("unexpected run length: exp done seen running");
            wrap_up();
        end
    end
    // register write, address and data offered together
    task automatic wr(input [31:0] d, input [3:0] s,
                      input [7:0] a = `WDR_OFFSET);
        @(posedge aclk);
        bq.push_back(a == `WDR_OFFSET ? `RESP_OKAY : `RESP_SLVERR);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask
    // register read with noted answer
    task automatic rd(input [7:0] a, input [33:0] e);
        @(posedge aclk);
        rq.push_back(e);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rready <= 1'b0;
    endtask
    // wait for internal reset level within a cycle window
    task automatic wt(input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (mcu_reset_r !== v && n <= hi) begin
            @(posedge aclk);
            n++;
        end
        num_checks++;
        if (n < lo || n > hi) begin
            err_count++;
            $display("unexpected reset delay: exp %0d..%0d seen %0d",
                     lo, hi, n);
        end
    endtask
    // level check of one status output
    task automatic chk(input string nm, input logic e, input logic g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: exp %b seen %b", nm, e, g);
        end
    endtask
    // one-cycle stop or wake pulse, then let outputs settle
    task automatic pls(input bit w);
        @(posedge aclk);
        if (w) wake <= 1'b1;
        else stop <= 1'b1;
        @(posedge aclk);
        stop <= 1'b0;
        wake <= 1'b0;
        @(posedge aclk);
    endtask
    initial begin
        seed = 32'h6E34;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rd(`WDR_OFFSET, {`RESP_OKAY, 32'h000000FE});
        wt(1'b0, 2030, 2070);
        rd(8'hDC, {`RESP_SLVERR, 32'h00000000});
        chk("wdg_active_r", 1'b0, act);
        $display("test reset done");
        r = $random(seed);
        wr({r[23:0], 8'hFC}, 4'hF);
        wr(32'h00000001, {r[27:25], 1'b0});
        wr(32'h00000003, 4'hF, 8'hD4);
        repeat (10) @(posedge aclk);
        chk("mcu_reset_r", 1'b0, mcu_reset_r);
        chk("wdg_active_r", 1'b0, act);
        pls(0);
        chk("osc_halted_r", 1'b1, osc_halted_r);
        pls(1);
        chk("osc_halted_r", 1'b0, osc_halted_r);
        $display("test inactive done");
        wr(32'h00000003, 4'hF);
        chk("wdg_active_r", 1'b1, act);
        wr(32'h00000002, 4'hF);
        chk("wdg_active_r", 1'b1, act);
        wt(1'b1, 2980, 3300);
        wt(1'b0, 2040, 2075);
        chk("wdg_active_r", 1'b0, act);
        rd(`WDR_OFFSET, {`RESP_OKAY, 32'h000000FE});
        $display("test expiry done");
        wr(32'h00000003, 4'hF);
        wr(32'h000000FD, 4'hF);
        wt(1'b1, 0, 6);
        hw <= 1'b1;
        ext <= 1'b1;
        nmi <= 1'b1;
        wt(1'b0, 2030, 2075);
        $display("test software reset done");
        rd(`WDR_OFFSET, {`RESP_OKAY, 32'h000000FF});
        chk("wdg_active_r", 1'b1, act);
        wr(32'h00000083, 4'hF);
        pls(0);
        chk("osc_halted_r", 1'b1, osc_halted_r);
        repeat (7000) @(posedge aclk);
        chk("mcu_reset_r", 1'b0, mcu_reset_r);
        pls(1);
        chk("osc_halted_r", 1'b0, osc_halted_r);
        wt(1'b1, 0, 6300);
        nmi <= 1'b0;
        wt(1'b0, 2030, 2075);
        $display("test frozen stop done");
        for (int e = 0; e < 2; e++) begin
            wr(32'h00000003, 4'hF);
            pls(0);
            chk("cpu_wait_r", 1'b1, cpu_wait_r);
            chk("osc_halted_r", 1'b0, osc_halted_r);
            wt(1'b1, 0, 3300);
            ext <= 1'b0;
            wt(1'b0, 2030, 2075);
            $display("test stop as wait done");
        end
        wrap_up();
    end
endmodule
